//--- inc/pes_pkg.sv
// constants, types and decode helpers shared by the port error status block
package pes_pkg;

    // register map
    localparam int          PES_AW            = 12;
    localparam int          PES_DW            = 32;
    localparam logic [11:0] PES_ERR_STAT_OFS  = 12'h058;
    localparam logic [11:0] PES_IRQ_STAT_OFS  = 12'h100;
    localparam logic [11:0] PES_IRQ_CLR_OFS   = 12'h104;
    localparam logic [11:0] PES_IRQ_EN_OFS    = 12'h108;

    // field positions of the error and status word
    localparam int PES_B_IDLE2_SUP  = 31;
    localparam int PES_B_IDLE2_EN   = 30;
    localparam int PES_B_IDLE_ACT   = 29;
    localparam int PES_B_FLOW_TX    = 27;
    localparam int PES_B_OR_ENC     = 20;
    localparam int PES_B_OR_RETRIED = 19;
    localparam int PES_B_OR_STOP    = 18;
    localparam int PES_B_OE_ENC     = 17;
    localparam int PES_B_OE_STOP    = 16;
    localparam int PES_B_IR_STOP    = 10;
    localparam int PES_B_IE_ENC     = 9;
    localparam int PES_B_IE_STOP    = 8;
    localparam int PES_B_PORT_ERR   = 2;
    localparam int PES_B_PORT_OK    = 1;
    localparam int PES_B_UNINIT     = 0;

    localparam logic [31:0] PES_DEFINED_MASK = 32'hE81F_0707;
    localparam logic        PES_RST_FLAG     = 1'b0;
    localparam logic        PES_RST_UNINIT   = 1'b1;

    // interrupt event layout
    localparam int PES_EV_OUT_RETRY = 0;
    localparam int PES_EV_OUT_ERR   = 1;
    localparam int PES_EV_IN_ERR    = 2;
    localparam int PES_EV_PORT_ERR  = 3;
    localparam int PES_EV_LINK_UP   = 4;
    localparam int PES_NEV          = 5;

    // ahb-lite encodings
    localparam logic [2:0] PES_HSIZE_WORD = 3'h2;
    localparam logic       PES_HRESP_OKAY = 1'b0;

    typedef enum logic [3:0] {
        PES_BUS_IDLE  = 4'h1,
        PES_BUS_WDATA = 4'h2,
        PES_BUS_RWAIT = 4'h4,
        PES_BUS_RDONE = 4'h8
    } pes_bus_st_t;

    typedef enum logic [2:0] {
        PES_LNK_OK    = 3'h1,
        PES_LNK_RETRY = 3'h2,
        PES_LNK_ERR   = 3'h4
    } pes_lnk_st_t;

    function automatic logic pes_hit(input logic [PES_AW-1:0] a, input logic [PES_AW-1:0] ofs);
        return a == ofs;
    endfunction

endpackage

//--- inc/pes_regbus_if.sv
// register access strobes between the bus slave and the register modules
`timescale 1ns/10ps
interface pes_regbus_if;
    import pes_pkg::*;
    logic              wr_en;
    logic [PES_AW-1:0] addr;
    logic [PES_DW-1:0] wdata;
    logic [PES_DW-1:0] rdata_csr;
    logic [PES_DW-1:0] rdata_irq;

    modport bus (output wr_en, output addr, output wdata, input rdata_csr, input rdata_irq);
    modport csr (input wr_en, input addr, input wdata, output rdata_csr);
    modport irq (input wr_en, input addr, input wdata, output rdata_irq);
endinterface

//--- rtl/pes_ahb_slave.sv
// ahb-lite slave turning transfers into register strobes
`timescale 1ns/10ps
module pes_ahb_slave
    import pes_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // ahb-lite
    input  wire logic              hsel,
    input  wire logic [PES_AW-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [PES_DW-1:0] hwdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [PES_DW-1:0]      hrdata,
    // register side
    pes_regbus_if.bus              rb
);

    pes_bus_st_t       st_reg,    st_next;
    logic [PES_AW-1:0] addr_reg,  addr_next;
    logic [PES_DW-1:0] rdata_reg, rdata_next;
    logic              take;

    // htrans[1] marks NONSEQ or SEQ
    assign take = hsel & htrans[1] & hready;

    always_comb begin
        st_next    = st_reg;
        addr_next  = addr_reg;
        rdata_next = rdata_reg;
        case (st_reg)
            PES_BUS_RWAIT: begin
                rdata_next = rb.rdata_csr | rb.rdata_irq;
                st_next    = PES_BUS_RDONE;
            end
            PES_BUS_IDLE, PES_BUS_WDATA, PES_BUS_RDONE: begin
                st_next = PES_BUS_IDLE;
                if (take) begin
                    addr_next = haddr;
                    if (!hwrite)
                        st_next = PES_BUS_RWAIT;
                    else if (hsize == PES_HSIZE_WORD)
                        st_next = PES_BUS_WDATA;
                end
            end
            default: st_next = PES_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg    <= PES_BUS_IDLE;
            addr_reg  <= '0;
            rdata_reg <= '0;
        end else begin
            st_reg    <= st_next;
            addr_reg  <= addr_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rb.wr_en  = (st_reg == PES_BUS_WDATA);
    assign rb.addr   = addr_reg;
    assign rb.wdata  = hwdata;
    assign hreadyout = (st_reg != PES_BUS_RWAIT);
    assign hresp     = PES_HRESP_OKAY;
    assign hrdata    = rdata_reg;

endmodule // pes_ahb_slave

//--- rtl/pes_irq.sv
// sticky event status, enable and write-only clear with one level interrupt
`timescale 1ns/10ps
module pes_irq
    import pes_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    // registers
    pes_regbus_if.irq               rb,
    // events and interrupt
    input  wire logic [PES_NEV-1:0] events,
    output logic                    irq
);

    logic [PES_NEV-1:0] stat_reg, stat_next;
    logic [PES_NEV-1:0] en_reg,   en_next;
    logic [PES_NEV-1:0] clr;

    always_comb begin
        clr       = (rb.wr_en && pes_hit(rb.addr, PES_IRQ_CLR_OFS)) ? rb.wdata[PES_NEV-1:0] : '0;
        // a new event beats a clear in the same cycle
        stat_next = (stat_reg & ~clr) | events;
        en_next   = (rb.wr_en && pes_hit(rb.addr, PES_IRQ_EN_OFS)) ? rb.wdata[PES_NEV-1:0] : en_reg;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stat_reg <= '0;
            en_reg   <= '0;
        end else begin
            stat_reg <= stat_next;
            en_reg   <= en_next;
        end
    end

    always_comb begin
        rb.rdata_irq = '0;
        if (pes_hit(rb.addr, PES_IRQ_STAT_OFS))
            rb.rdata_irq[PES_NEV-1:0] = stat_reg;
        else if (pes_hit(rb.addr, PES_IRQ_EN_OFS))
            rb.rdata_irq[PES_NEV-1:0] = en_reg;
    end

    assign irq = |(stat_reg & en_reg);

endmodule // pes_irq

//--- rtl/pes_top.sv
// port error and status register with link recovery tracking
// Overview of operation
// - bit 31: fixed idle-2 support flag
// - bit 30: idle select, writable only when allowed
// - bit 29: idle sequence currently active
// - bit 27: fixed flow control mode
// - bit 20: sticky output retry, write-one clears
// - bit 19: last output response was retry
// - bit 18: output side retry-stopped
// - bit 17: sticky output error, write-one clears
// - bit 16: output error-stopped until link response
// - bit 10: input retry-stopped until restart symbol or input error
// - bit 9: sticky input error, write-one clears
// - bit 8: input error-stopped until link request
// - bit 2: sticky unrecoverable port error
// - bit 1 port ok, bit 0 uninitialized
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module pes_top
    import pes_pkg::*;
#(
    parameter logic IDLE2_SUPPORT  = 1'b1,
    parameter logic RATE_ABOVE_5G5 = 1'b0,
    parameter logic IDLE2_EN_INIT  = 1'b1,
    parameter logic FLOW_TX        = 1'b0
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // ahb-lite
    input  wire logic              hsel,
    input  wire logic [PES_AW-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [PES_DW-1:0] hwdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [PES_DW-1:0]      hrdata,
    // received control symbols, one-cycle pulses
    input  wire logic              sym_pkt_retry,
    input  wire logic              sym_pkt_accepted,
    input  wire logic              sym_pkt_not_accepted,
    input  wire logic              sym_link_response,
    input  wire logic              sym_link_request,
    input  wire logic              sym_restart_retry,
    // physical layer events, one-cycle pulses
    input  wire logic              tx_restart_retry,
    input  wire logic              out_err_detect,
    input  wire logic              in_retry_issue,
    input  wire logic              in_err_detect,
    input  wire logic              fatal_err,
    // physical layer levels
    input  wire logic              port_init,
    input  wire logic              sym_error_free,
    input  wire logic              idle2_active,
    // status
    output logic                   idle2_en,
    output logic                   irq
);

    localparam logic IDLE_EN_WR_OK = IDLE2_SUPPORT & ~RATE_ABOVE_5G5;

    pes_regbus_if rb ();

    pes_lnk_st_t out_st_reg, out_st_next;
    pes_lnk_st_t in_st_reg,  in_st_next;
    logic idle2_en_reg,   idle2_en_next;
    logic idle_act_reg,   idle_act_next;
    logic or_enc_reg,     or_enc_next;
    logic or_retried_reg, or_retried_next;
    logic oe_enc_reg,     oe_enc_next;
    logic ie_enc_reg,     ie_enc_next;
    logic port_err_reg,   port_err_next;
    logic port_ok_reg,    port_ok_next;
    logic uninit_reg,     uninit_next;
    logic                 wr_hit;
    logic [PES_DW-1:0]    csr;
    logic [PES_NEV-1:0]   events;

    pes_ahb_slave u_bus (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .rb        (rb.bus)
    );

    pes_irq u_irq (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .rb      (rb.irq),
        .events  (events),
        .irq     (irq)
    );

    assign wr_hit = rb.wr_en & pes_hit(rb.addr, PES_ERR_STAT_OFS);

    // output side recovery: error outranks retry
    always_comb begin
        out_st_next = out_st_reg;
        case (out_st_reg)
            PES_LNK_OK:
                if (out_err_detect)
                    out_st_next = PES_LNK_ERR;
                else if (sym_pkt_retry)
                    out_st_next = PES_LNK_RETRY;
            PES_LNK_RETRY:
                if (out_err_detect)
                    out_st_next = PES_LNK_ERR;
                else if (tx_restart_retry)
                    out_st_next = PES_LNK_OK;
            PES_LNK_ERR:
                if (sym_link_response)
                    out_st_next = PES_LNK_OK;
            default: out_st_next = PES_LNK_OK;
        endcase
    end

    // input side recovery
    always_comb begin
        in_st_next = in_st_reg;
        case (in_st_reg)
            PES_LNK_OK:
                if (in_err_detect)
                    in_st_next = PES_LNK_ERR;
                else if (in_retry_issue)
                    in_st_next = PES_LNK_RETRY;
            PES_LNK_RETRY:
                if (in_err_detect)
                    in_st_next = PES_LNK_ERR;
                else if (sym_restart_retry)
                    in_st_next = PES_LNK_OK;
            PES_LNK_ERR:
                if (sym_link_request)
                    in_st_next = PES_LNK_OK;
            default: in_st_next = PES_LNK_OK;
        endcase
    end

    // flags: a set in the clearing cycle wins
    always_comb begin
        idle2_en_next = idle2_en_reg;
        if (IDLE_EN_WR_OK && wr_hit)
            idle2_en_next = rb.wdata[PES_B_IDLE2_EN];
        idle_act_next   = idle2_active;
        or_enc_next     = sym_pkt_retry | (or_enc_reg & ~(wr_hit & rb.wdata[PES_B_OR_ENC]));
        or_retried_next = sym_pkt_retry | (or_retried_reg & ~(sym_pkt_accepted | sym_pkt_not_accepted));
        oe_enc_next     = out_err_detect | (oe_enc_reg & ~(wr_hit & rb.wdata[PES_B_OE_ENC]));
        ie_enc_next     = in_err_detect | (ie_enc_reg & ~(wr_hit & rb.wdata[PES_B_IE_ENC]));
        port_err_next   = fatal_err | (port_err_reg & ~(wr_hit & rb.wdata[PES_B_PORT_ERR]));
        port_ok_next    = port_init & sym_error_free;
        uninit_next     = ~port_init;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            out_st_reg     <= PES_LNK_OK;
            in_st_reg      <= PES_LNK_OK;
            idle2_en_reg   <= IDLE2_EN_INIT;
            idle_act_reg   <= PES_RST_FLAG;
            or_enc_reg     <= PES_RST_FLAG;
            or_retried_reg <= PES_RST_FLAG;
            oe_enc_reg     <= PES_RST_FLAG;
            ie_enc_reg     <= PES_RST_FLAG;
            port_err_reg   <= PES_RST_FLAG;
            port_ok_reg    <= PES_RST_FLAG;
            uninit_reg     <= PES_RST_UNINIT;
        end else begin
            out_st_reg     <= out_st_next;
            in_st_reg      <= in_st_next;
            idle2_en_reg   <= idle2_en_next;
            idle_act_reg   <= idle_act_next;
            or_enc_reg     <= or_enc_next;
            or_retried_reg <= or_retried_next;
            oe_enc_reg     <= oe_enc_next;
            ie_enc_reg     <= ie_enc_next;
            port_err_reg   <= port_err_next;
            port_ok_reg    <= port_ok_next;
            uninit_reg     <= uninit_next;
        end
    end

    // read view; unlisted bits stay zero
    always_comb begin
        csr                   = '0;
        csr[PES_B_IDLE2_SUP]  = IDLE2_SUPPORT;
        csr[PES_B_IDLE2_EN]   = idle2_en_reg;
        csr[PES_B_IDLE_ACT]   = idle_act_reg;
        csr[PES_B_FLOW_TX]    = FLOW_TX;
        csr[PES_B_OR_ENC]     = or_enc_reg;
        csr[PES_B_OR_RETRIED] = or_retried_reg;
        csr[PES_B_OR_STOP]    = (out_st_reg == PES_LNK_RETRY);
        csr[PES_B_OE_ENC]     = oe_enc_reg;
        csr[PES_B_OE_STOP]    = (out_st_reg == PES_LNK_ERR);
        csr[PES_B_IR_STOP]    = (in_st_reg == PES_LNK_RETRY);
        csr[PES_B_IE_ENC]     = ie_enc_reg;
        csr[PES_B_IE_STOP]    = (in_st_reg == PES_LNK_ERR);
        csr[PES_B_PORT_ERR]   = port_err_reg;
        csr[PES_B_PORT_OK]    = port_ok_reg;
        csr[PES_B_UNINIT]     = uninit_reg;
    end

    assign rb.rdata_csr = pes_hit(rb.addr, PES_ERR_STAT_OFS) ? csr : '0;
    assign idle2_en     = idle2_en_reg;

    always_comb begin
        events                   = '0;
        events[PES_EV_OUT_RETRY] = sym_pkt_retry;
        events[PES_EV_OUT_ERR]   = out_err_detect;
        events[PES_EV_IN_ERR]    = in_err_detect;
        events[PES_EV_PORT_ERR]  = fatal_err;
        events[PES_EV_LINK_UP]   = port_ok_next & ~port_ok_reg;
    end

    idle_sup_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        pes_hit(rb.addr, PES_ERR_STAT_OFS) |-> rb.rdata_csr[PES_B_IDLE2_SUP] == IDLE2_SUPPORT)
        else $error("idle-2 support bit changed");

    idle_en_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(IDLE_EN_WR_OK && wr_hit) |=> $stable(csr[PES_B_IDLE2_EN])) else $error("read-only idle select moved");

    idle_act_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        idle2_active |=> csr[PES_B_IDLE_ACT]) else $error("active idle not reported");

    flow_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        pes_hit(rb.addr, PES_ERR_STAT_OFS) |-> rb.rdata_csr[PES_B_FLOW_TX] == FLOW_TX)
        else $error("flow control mode wrong");

    or_enc_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sym_pkt_retry |=> csr[PES_B_OR_ENC] && csr[PES_B_OR_RETRIED]) else $error("output retry not flagged");

    or_retried_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (sym_pkt_accepted || sym_pkt_not_accepted) && !sym_pkt_retry |=> !csr[PES_B_OR_RETRIED])
        else $error("retried bit not cleared by response");

    or_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_OR_STOP] && tx_restart_retry && !out_err_detect |=> !csr[PES_B_OR_STOP])
        else $error("output retry-stopped did not end");

    oe_enc_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_OE_ENC] && !(wr_hit && rb.wdata[PES_B_OE_ENC]) |=> csr[PES_B_OE_ENC])
        else $error("output error flag lost");

    oe_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        out_err_detect ##1 !sym_link_response [*2] |-> csr[PES_B_OE_STOP]) else $error("output error-stopped left early");

    ir_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_IR_STOP] && !sym_restart_retry && !in_err_detect |=> csr[PES_B_IR_STOP])
        else $error("input retry-stopped left early");

    ie_enc_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_err_detect |=> csr[PES_B_IE_ENC] && csr[PES_B_IE_STOP]) else $error("input error not flagged");

    ie_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_IE_STOP] && sym_link_request |=> !csr[PES_B_IE_STOP]) else $error("link request did not clear input");

    port_err_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        fatal_err |=> csr[PES_B_PORT_ERR]) else $error("port error not flagged");

    port_ok_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_PORT_OK] |-> !csr[PES_B_UNINIT] && $past(sym_error_free)) else $error("port ok while not ready");

    reserved_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (rb.rdata_csr & ~PES_DEFINED_MASK) == '0) else $error("reserved bit reads nonzero");

    idle_en_wr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        IDLE_EN_WR_OK && wr_hit |=> csr[PES_B_IDLE2_EN] == $past(rb.wdata[PES_B_IDLE2_EN]))
        else $error("idle select write lost");

    idle_act_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !idle2_active |=> !csr[PES_B_IDLE_ACT])
        else $error("inactive idle still reported");

    or_enc_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_hit && rb.wdata[PES_B_OR_ENC] && !sym_pkt_retry |=> !csr[PES_B_OR_ENC])
        else $error("output retry flag not cleared");

    or_enc_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_OR_ENC] && !(wr_hit && rb.wdata[PES_B_OR_ENC]) |=> csr[PES_B_OR_ENC])
        else $error("output retry flag lost");

    or_stop_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !csr[PES_B_OR_STOP] && !csr[PES_B_OE_STOP] && sym_pkt_retry && !out_err_detect |=> csr[PES_B_OR_STOP])
        else $error("output retry-stopped not entered");

    out_excl_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(csr[PES_B_OR_STOP] && csr[PES_B_OE_STOP]))
        else $error("output stop bits both set");

    oe_enc_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        out_err_detect |=> csr[PES_B_OE_ENC] && csr[PES_B_OE_STOP])
        else $error("output error not flagged");

    oe_enc_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_hit && rb.wdata[PES_B_OE_ENC] && !out_err_detect |=> !csr[PES_B_OE_ENC])
        else $error("output error flag not cleared");

    oe_stop_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_OE_STOP] && !sym_link_response |=> csr[PES_B_OE_STOP])
        else $error("output error-stopped ended early");

    ir_stop_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !csr[PES_B_IR_STOP] && !csr[PES_B_IE_STOP] && in_retry_issue && !in_err_detect |=> csr[PES_B_IR_STOP])
        else $error("input retry-stopped not entered");

    in_excl_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(csr[PES_B_IR_STOP] && csr[PES_B_IE_STOP]))
        else $error("input stop bits both set");

    ie_enc_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_hit && rb.wdata[PES_B_IE_ENC] && !in_err_detect |=> !csr[PES_B_IE_ENC])
        else $error("input error flag not cleared");

    ie_enc_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_IE_ENC] && !(wr_hit && rb.wdata[PES_B_IE_ENC]) |=> csr[PES_B_IE_ENC])
        else $error("input error flag lost");

    ie_stop_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_IE_STOP] && !sym_link_request |=> csr[PES_B_IE_STOP])
        else $error("input error-stopped ended early");

    port_err_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_hit && rb.wdata[PES_B_PORT_ERR] && !fatal_err |=> !csr[PES_B_PORT_ERR])
        else $error("port error not cleared");

    port_err_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csr[PES_B_PORT_ERR] && !(wr_hit && rb.wdata[PES_B_PORT_ERR]) |=> csr[PES_B_PORT_ERR])
        else $error("port error flag lost");

    uninit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !port_init |=> csr[PES_B_UNINIT] && !csr[PES_B_PORT_OK])
        else $error("uninitialized port not reported");

    port_ok_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        port_init && sym_error_free |=> csr[PES_B_PORT_OK] && !csr[PES_B_UNINIT])
        else $error("ready port not reported ok");

endmodule // pes_top

//--- verification/pes_top_tb_top.sv
// self-checking bench for the port error status register block
`timescale 1ns/10ps
module pes_top_tb_top;
    import pes_pkg::*;

    localparam int        E_RETRY = 0, E_ACC = 1, E_NACC = 2, E_LRSP = 3, E_LREQ = 4, E_RST = 5;
    localparam int        E_TXRST = 6, E_OERR = 7, E_IRTY = 8, E_IERR = 9, E_FATAL = 10;
    localparam logic [31:0] BASE = 32'hC000_0001;

    logic              clk_sys = 1'b0;
    logic              nrst    = 1'b0;
    logic              hsel    = 1'b0;
    logic [PES_AW-1:0] haddr   = 12'h000;
    logic [1:0]        htrans  = 2'h0;
    logic              hwrite  = 1'b0;
    logic [2:0]        hsize   = 3'h2;
    logic [PES_DW-1:0] hwdata  = 32'h0000_0000;
    logic              hreadyout;
    logic              hresp;
    logic [PES_DW-1:0] hrdata;
    logic [10:0]       ev      = 11'h000;
    logic              port_init = 1'b0;
    logic              sym_error_free = 1'b0;
    logic              idle2_active = 1'b0;
    logic              idle2_en;
    logic              irq;
    int                n_fail   = 0;
    int                n_checks = 0;

    always #25 clk_sys = ~clk_sys;

    pes_top uut (
        .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sym_pkt_retry(ev[E_RETRY]), .sym_pkt_accepted(ev[E_ACC]),
        .sym_pkt_not_accepted(ev[E_NACC]), .sym_link_response(ev[E_LRSP]), .sym_link_request(ev[E_LREQ]),
        .sym_restart_retry(ev[E_RST]), .tx_restart_retry(ev[E_TXRST]), .out_err_detect(ev[E_OERR]),
        .in_retry_issue(ev[E_IRTY]), .in_err_detect(ev[E_IERR]), .fatal_err(ev[E_FATAL]),
        .port_init(port_init), .sym_error_free(sym_error_free), .idle2_active(idle2_active),
        .idle2_en(idle2_en), .irq(irq)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one ahb-lite transfer; waits on hready in both phases
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [2:0] sz,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= a;
        hsize  <= sz;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, {31'h0, PES_HRESP_OKAY});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, PES_HSIZE_WORD, d, dummy);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, a, PES_HSIZE_WORD, 32'h0000_0000, d);
        chk(d, exp);
    endtask

    task automatic pulse(input int idx);
        @(posedge clk_sys);
        ev <= 11'h001 << idx;
        @(posedge clk_sys);
        ev <= 11'h000;
    endtask

    task automatic t_reset_and_writes;
        logic [31:0] d;
        rchk(PES_ERR_STAT_OFS, BASE);
        rchk(12'h058, BASE);
        chk({31'h0, idle2_en}, 32'h1);
        wr(PES_ERR_STAT_OFS, 32'h0000_0000);
        rchk(PES_ERR_STAT_OFS, 32'h8000_0001);
        chk({31'h0, idle2_en}, 32'h0);
        xfer(1'b1, PES_ERR_STAT_OFS, 3'h0, 32'hFFFF_FFFF, d);
        rchk(PES_ERR_STAT_OFS, 32'h8000_0001);
        wr(PES_ERR_STAT_OFS, 32'hFFFF_FFFF);
        rchk(PES_ERR_STAT_OFS, BASE);
        rchk(12'h0F0, 32'h0000_0000);
    endtask

    task automatic t_out_retry;
        int k;
        for (k = E_ACC; k <= E_NACC; k++) begin
            pulse(E_RETRY);
            rchk(PES_ERR_STAT_OFS, BASE | 32'h001C_0000);
            pulse(E_TXRST);
            rchk(PES_ERR_STAT_OFS, BASE | 32'h0018_0000);
            pulse(k);
            rchk(PES_ERR_STAT_OFS, BASE | 32'h0010_0000);
            wr(PES_ERR_STAT_OFS, 32'h4010_0000);
            rchk(PES_ERR_STAT_OFS, BASE);
        end
    endtask

    task automatic t_out_err;
        pulse(E_OERR);
        rchk(PES_ERR_STAT_OFS, BASE | 32'h0003_0000);
        wr(PES_ERR_STAT_OFS, 32'h6000_0000);
        rchk(PES_ERR_STAT_OFS, BASE | 32'h0003_0000);
        pulse(E_LRSP);
        rchk(PES_ERR_STAT_OFS, BASE | 32'h0002_0000);
        wr(PES_ERR_STAT_OFS, 32'h4002_0000);
        rchk(PES_ERR_STAT_OFS, BASE);
    endtask

    task automatic t_in_side;
        pulse(E_IRTY);
        rchk(PES_ERR_STAT_OFS, BASE | 32'h0000_0400);
        pulse(E_LREQ);
        rchk(PES_ERR_STAT_OFS, BASE | 32'h0000_0400);
        pulse(E_RST);
        rchk(PES_ERR_STAT_OFS, BASE);
        pulse(E_IERR);
        rchk(PES_ERR_STAT_OFS, BASE | 32'h0000_0300);
        pulse(E_LREQ);
        rchk(PES_ERR_STAT_OFS, BASE | 32'h0000_0200);
        wr(PES_ERR_STAT_OFS, 32'h4000_0200);
        rchk(PES_ERR_STAT_OFS, BASE);
    endtask

    task automatic t_port;
        pulse(E_FATAL);
        rchk(PES_ERR_STAT_OFS, BASE | 32'h0000_0004);
        wr(PES_ERR_STAT_OFS, 32'h4000_0004);
        rchk(PES_ERR_STAT_OFS, BASE);
        port_init <= 1'b1;
        rchk(PES_ERR_STAT_OFS, 32'hC000_0000);
        sym_error_free <= 1'b1;
        idle2_active   <= 1'b1;
        rchk(PES_ERR_STAT_OFS, 32'hE000_0002);
        rchk(PES_ERR_STAT_OFS, 32'hE000_0002);
    endtask

    task automatic t_irq;
        wr(PES_IRQ_CLR_OFS, 32'h0000_001F);
        rchk(PES_IRQ_STAT_OFS, 32'h0000_0000);
        rchk(PES_IRQ_EN_OFS, 32'h0000_0000);
        pulse(E_FATAL);
        rchk(PES_IRQ_STAT_OFS, 32'h0000_0008);
        chk({31'h0, irq}, 32'h0);
        wr(PES_IRQ_EN_OFS, 32'h0000_001F);
        rchk(PES_IRQ_EN_OFS, 32'h0000_001F);
        chk({31'h0, irq}, 32'h1);
        rchk(PES_IRQ_CLR_OFS, 32'h0000_0000);
        wr(PES_IRQ_CLR_OFS, 32'h0000_0008);
        rchk(PES_IRQ_STAT_OFS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0);
        pulse(E_OERR);
        rchk(PES_IRQ_STAT_OFS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h1);
    endtask

    task automatic close_out;
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset_and_writes();
        t_out_retry();
        t_out_err();
        t_in_side();
        t_port();
        t_irq();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end

endmodule // pes_top_tb_top
